// ===== verification/sepc_eeprom_model.sv
`timescale 1ns/1ns
// Serial memory seen from the pins; busy time is cut short for simulation.
module sepc_eeprom_model
  import sepc_pkg::*;
#(
  parameter int BUSY_CYC = 60
) (
  // Clock used to time the self-timed cycle and to record the last driven output level.
  input wire logic clk,
  // Pins driven by the host.
  input wire logic chipSelect,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  input wire logic word_width_select,
  // Output pin, with no pull on the line.
  output logic serialOut
);
  logic [15:0] mem [256];
  logic [27:0] sr;
  logic [15:0] dat;
  logic latch = 1'b0;
  logic started = 1'b0, reading = 1'b0, statusOn = 1'b0, busyOn = 1'b0, pend = 1'b0;
  logic outBit = 1'b0, lastOut = 1'b0;
  logic [1:0] op, sub;
  logic [8:0] adr;
  int nBits, rdBit, ab, dw, cyc = 0, busyStart = 0;
  wire logic busy = busyOn && (cyc - busyStart < BUSY_CYC);
  wire logic drv = chipSelect && (reading || (statusOn && !started));
  // A released line shows the inverse of its last level, so stale data never passes.
  assign serialOut = drv ? (reading ? outBit : !busy) : !lastOut;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'(i);
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (drv) lastOut <= serialOut;
  end
  // Frame decoder; the select falling edge launches a pending program cycle only while the latch is set.
  always @(posedge serial_clock_in or negedge chipSelect) begin
    ab = word_width_select ? 8 : 9;
    dw = word_width_select ? 16 : 8;
    if (!chipSelect) begin
      if (pend && latch) begin
        if (op == OP_WRITE) mem[adr] = dat;
        else if (op == OP_ERASE) mem[adr] = 16'hffff;
        else for (int i = 0; i < 256; i++) mem[i] = (sub == SUB_FILL) ? dat : 16'hffff;
        busyOn = 1'b1;
        busyStart = cyc;
        statusOn = 1'b1;
      end
      pend = 1'b0;
      started = 1'b0;
      reading = 1'b0;
    end else if (busy) begin
      // Frames are dropped while the cycle runs.
    end else if (!started) begin
      started = serial_in;
      nBits = 0;
    end else if (reading) begin
      outBit = mem[adr][rdBit];
      if (rdBit == 0) begin
        adr = (adr + 9'h1) & (word_width_select ? 9'h07f : 9'h0ff);
        rdBit = dw - 1;
      end else rdBit--;
    end else begin
      sr = {sr[26:0], serial_in};
      nBits++;
      if (nBits == 2 + ab) begin
        op = sr[ab+1 -: 2];
        sub = sr[ab-1 -: 2];
        adr = sr[8:0] & (word_width_select ? 9'h07f : 9'h0ff);
        reading = (op == OP_READ);
        outBit = 1'b0;
        rdBit = dw - 1;
        if (op == OP_SPECIAL && sub == SUB_UNLOCK) latch = 1'b1;
        if (op == OP_SPECIAL && sub == SUB_LOCK) latch = 1'b0;
        pend = op == OP_ERASE || (op == OP_SPECIAL && sub == SUB_CLEAR);
      end
      if (nBits == 2 + ab + dw && (op == OP_WRITE || (op == OP_SPECIAL && sub == SUB_FILL))) begin
        dat = word_width_select ? sr[15:0] : {8'h00, sr[7:0]};
        pend = 1'b1;
      end
    end
  end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  import sepc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, reqValid = 1'b0;
  sepc_req_t req = '0;
  logic [7:0] burstWords = 8'h01;
  logic reqReady, rdValid, doneValid, timeoutErr, chipSelect, serial_clock_in, serial_in;
  logic word_width_select, serialOut;
  logic [15:0] rdData;
  logic [15:0] got [$];
  int error_cnt = 0, n_tests = 0, cyc = 0;
  sepc_host #(.PROG_TIMEOUT(200)) sepc_host_inst (.clk(clk), .rst(rst), .reqValid(reqValid),
    .req(req), .burstWords(burstWords), .reqReady(reqReady), .rdData(rdData),
    .rdValid(rdValid), .doneValid(doneValid), .timeoutErr(timeoutErr),
    .chipSelect(chipSelect), .serial_clock_in(serial_clock_in), .serial_in(serial_in),
    .word_width_select(word_width_select), .serialOut(serialOut));
  sepc_eeprom_model #(.BUSY_CYC(60)) sepc_eeprom_model_inst (.clk(clk),
    .chipSelect(chipSelect), .serial_clock_in(serial_clock_in), .serial_in(serial_in),
    .word_width_select(word_width_select), .serialOut(serialOut));
  initial forever #10 clk = ~clk;
  // Read words are gathered on the falling edge, where they have settled.
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (rdValid === 1'b1) got.push_back(rdData);
    if (cyc == 80000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(logic [15:0] g, logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  // One request held until taken, then a bounded wait for its end pulse.
  task automatic op(logic [1:0] o, logic [8:0] a, logic [15:0] d, logic bm, int n);
    int w = 0;
    got.delete();
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{o, a, d, bm};
    burstWords <= 8'(n);
    do @(posedge clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    do begin
      @(negedge clk);
      w++;
    end while (doneValid !== 1'b1 && w < 20000);
    chk({15'h0, doneValid}, 16'h0001);
    @(posedge clk);
    chk({15'h0, timeoutErr}, 16'h0000);
  endtask
  // Read a burst and compare every word; byte mode keeps the low eight bits.
  task automatic rd(logic [8:0] a, logic bm, logic [15:0] e [$]);
    op(OP_READ, a, 16'h0000, bm, e.size());
    chk(16'(got.size()), 16'(e.size()));
    foreach (e[i]) chk(bm ? {8'h00, got[i][7:0]} : got[i], e[i]);
  endtask
  task automatic t_locked();
    op(OP_WRITE, 9'h005, 16'hbeef, 1'b0, 1);
    rd(9'h005, 1'b0, '{16'h0005});
  endtask
  task automatic t_write();
    op(OP_SPECIAL, 9'h0c0, 16'h0000, 1'b0, 1);
    op(OP_WRITE, 9'h005, 16'hbeef, 1'b0, 1);
    rd(9'h005, 1'b0, '{16'hbeef});
  endtask
  task automatic t_erase();
    op(OP_ERASE, 9'h005, 16'h0000, 1'b0, 1);
    rd(9'h005, 1'b0, '{16'hffff});
  endtask
  task automatic t_burst();
    rd(9'h07e, 1'b0, '{16'h007e, 16'h007f, 16'h0000});
  endtask
  task automatic t_byte();
    op(OP_SPECIAL, 9'h180, 16'h0000, 1'b1, 1);
    op(OP_WRITE, 9'h0c8, 16'h00a5, 1'b1, 1);
    rd(9'h0c8, 1'b1, '{16'h00a5, 16'h00c9});
  endtask
  task automatic t_fill();
    op(OP_SPECIAL, 9'h040, 16'h1234, 1'b0, 1);
    rd(9'h00a, 1'b0, '{16'h1234, 16'h1234});
  endtask
  task automatic t_clear();
    op(OP_SPECIAL, 9'h080, 16'h0000, 1'b0, 1);
    rd(9'h07f, 1'b0, '{16'hffff, 16'hffff});
  endtask
  task automatic t_lock();
    op(OP_SPECIAL, 9'h000, 16'h0000, 1'b0, 1);
    op(OP_WRITE, 9'h003, 16'h0000, 1'b0, 1);
    rd(9'h003, 1'b0, '{16'hffff});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_locked();
    t_write();
    t_erase();
    t_burst();
    t_byte();
    t_fill();
    t_clear();
    t_lock();
    complete_run();
  end
endmodule

// ===== verilog/sepc_host.sv
`timescale 1ns/1ns
// Operation
// RQ1: Frame is 11 or 12 bits.
// RQ2: Device samples serial_in on rising clock.
// RQ3: Device output tri-stated except read/status.
// RQ4: Start bit, opcode, address, then data.
// RQ5: Opcode 10 reads addressed location.
// RQ6: Opcode 11 clears addressed location.
// RQ7: Opcode 01 programs one word.
// RQ8: Opcode 00, leading 11 unlocks programming.
// RQ9: Opcode 00, leading 00 locks programming.
// RQ10: Opcode 00, leading 10 clears array.
// RQ11: Opcode 00, leading 01 fills array.
// RQ12: Host drives unused top address bit.
// RQ13: Raised select reports busy then ready.
// RQ14: Shifting a one releases the output.
// RQ15: Read gives dummy zero then MSB first.
// RQ16: Continued clocking streams next, wrapping.
// RQ17: Only first burst word has dummy zero.
// RQ18: Latch cleared at power-up, gates writes.
// RQ19: Latch stays until lock; reads unaffected.
// RQ20: Select low at least 0.25 us.
// RQ21: Erase falling edge clears location.
// RQ22: Program cycle finishes within 5 ms.
// RQ23: Width select high means word mode.
// RQ24: Array clear sets every bit one.
// RQ25: Array fill writes word everywhere.
// RQ26: Device ignores frames while busy.
module sepc_host
  import sepc_pkg::*;
#(
  parameter int PROG_TIMEOUT = PROGRAM_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Request side.
  input wire logic reqValid,
  input wire sepc_req_t req,
  input wire logic [7:0] burstWords,
  output logic reqReady,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic doneValid,
  output logic timeoutErr,
  // Device pins.
  output logic chipSelect,
  output logic serial_clock_in,
  output logic serial_in,
  output logic word_width_select,
  input wire logic serialOut
);
  sepc_state_t state_reg;
  sepc_req_t cur_reg;
  logic [31:0] outSh_reg;     // Bits still to send, MSB first.
  logic [5:0] outCnt_reg;     // Bits remaining in the command part.
  logic [5:0] inCnt_reg;      // Read bits still expected, dummy included.
  logic [7:0] wordsLeft_reg;  // Burst words remaining.
  logic [15:0] inSh_reg;
  logic [4:0] half_reg;       // Half period timer of serial_clock_in.
  logic [22:0] wait_reg;      // Deselect and busy timer.
  logic so1_reg;
  logic so2_reg;              // Synchronised device output.
  logic firstBit_reg;

  // The device output is a pin; two flops before anything reads it.
  always_ff @(posedge clk) begin
    so1_reg <= serialOut;
    so2_reg <= so1_reg;
  end

  // Leading address bits of a special code; they sit one bit higher in byte mode.
  // Reading a fixed slice would confuse unlock with fill in word mode.
  function automatic logic [1:0] subCode(input sepc_req_t r);
    subCode = r.byteMode ? r.addr[8:7] : r.addr[7:6]; // RQ8 RQ9
  endfunction

  // Address as sent: the unused top bit is pinned to zero for normal opcodes.
  function automatic logic [8:0] sendAddr(input sepc_req_t r);
    sendAddr = r.addr;
    if (r.op != OP_SPECIAL && r.byteMode) begin
      sendAddr[8] = 1'b0; // RQ12
    end else if (r.op != OP_SPECIAL) begin
      sendAddr[7] = 1'b0; // RQ12
    end
  endfunction

  // Whether this opcode starts a self-timed cycle on deselect.
  function automatic logic isProgram(input sepc_req_t r);
    isProgram = (r.op == OP_WRITE) || (r.op == OP_ERASE) || // RQ6 RQ7
                (r.op == OP_SPECIAL && (subCode(r) == SUB_CLEAR ||
                                        subCode(r) == SUB_FILL)); // RQ10 RQ11
  endfunction

  // Whether a data field follows the address.
  function automatic logic hasData(input sepc_req_t r);
    hasData = (r.op == OP_WRITE) || (r.op == OP_SPECIAL && subCode(r) == SUB_FILL); // RQ7 RQ11
  endfunction

  logic [8:0] reqAddr;  // Request address with the don't-care top bit defined.
  assign reqAddr = sendAddr(req);

  logic halfDone;
  assign halfDone = (half_reg == 5'(SK_HALF_CYC - 1));
  logic riseNow;  // The cycle on which serial_clock_in goes high.
  assign riseNow = halfDone && !serial_clock_in && state_reg == S_SHIFT;

  // Main sequencer: frame shifting, deselect gap, busy polling.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      chipSelect <= 1'b0;
      serial_clock_in <= 1'b0;
      serial_in <= 1'b0;
      word_width_select <= 1'b1;
      reqReady <= 1'b0;
      rdValid <= 1'b0;
      rdData <= 16'h0;
      doneValid <= 1'b0;
      timeoutErr <= 1'b0;
      half_reg <= 5'h0;
      wait_reg <= 23'h0;
      outCnt_reg <= 6'h0;
      inCnt_reg <= 6'h0;
      outSh_reg <= 32'h0;
      inSh_reg <= 16'h0;
      wordsLeft_reg <= 8'h0;
      cur_reg <= '0;
      firstBit_reg <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      doneValid <= 1'b0;
      unique case (state_reg)
        S_IDLE: begin
          reqReady <= 1'b1;
          if (reqValid && reqReady) begin
            reqReady <= 1'b0;
            cur_reg <= req;
            word_width_select <= !req.byteMode; // RQ23
            chipSelect <= 1'b1;
            half_reg <= 5'h0;
            firstBit_reg <= 1'b1;
            // The start bit rises with select, so the first clock rise samples it.
            // Opcode, address and data then follow MSB first, one per falling half.
            serial_in <= 1'b1; // RQ4 RQ14
            if (req.byteMode) begin
              outSh_reg <= {req.op, reqAddr, req.data[7:0], 13'h0}; // RQ4 RQ12
              outCnt_reg <= 6'(FRAME_BYTE_BITS + (hasData(req) ? DATA_BYTE_BITS : 0)); // RQ1
              inCnt_reg <= (req.op == OP_READ) ? 6'(DATA_BYTE_BITS + 1) : 6'h0; // RQ5 RQ15
            end else begin
              outSh_reg <= {req.op, reqAddr[7:0], req.data, 6'h0}; // RQ4 RQ12
              outCnt_reg <= 6'(FRAME_WORD_BITS + (hasData(req) ? DATA_WORD_BITS : 0)); // RQ1
              inCnt_reg <= (req.op == OP_READ) ? 6'(DATA_WORD_BITS + 1) : 6'h0; // RQ15
            end
            wordsLeft_reg <= (burstWords == 8'h0) ? 8'h1 : burstWords;
            state_reg <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          half_reg <= halfDone ? 5'h0 : half_reg + 5'h1;
          if (halfDone) begin
            serial_clock_in <= !serial_clock_in;
            if (serial_clock_in) begin
              // Falling edge: present the next bit before the rise.
              if (outCnt_reg != 6'h0) begin
                serial_in <= outSh_reg[31]; // RQ2
                outSh_reg <= {outSh_reg[30:0], 1'b0};
              end else begin
                serial_in <= 1'b0;
              end
            end
          end
          if (riseNow) begin
            if (outCnt_reg != 6'h0) begin
              outCnt_reg <= outCnt_reg - 6'h1;
            end else if (inCnt_reg != 6'h0) begin
              // Data bits follow the address; dummy zero only once.
              inSh_reg <= {inSh_reg[14:0], so2_reg}; // RQ15
              inCnt_reg <= inCnt_reg - 6'h1;
            end
          end
          // Finish a read word after its last falling half.
          if (halfDone && serial_clock_in && outCnt_reg == 6'h0 && inCnt_reg == 6'h0) begin
            if (cur_reg.op == OP_READ && !firstBit_reg) begin
              rdValid <= 1'b1;
              rdData <= inSh_reg;
            end
            if (cur_reg.op == OP_READ && wordsLeft_reg > 8'h1 && !firstBit_reg) begin
              wordsLeft_reg <= wordsLeft_reg - 8'h1; // RQ16
              inCnt_reg <= 6'(cur_reg.byteMode ? DATA_BYTE_BITS : DATA_WORD_BITS); // RQ17
            end else if (cur_reg.op == OP_READ && firstBit_reg) begin
              firstBit_reg <= 1'b0;
            end else begin
              chipSelect <= 1'b0; // RQ20
              serial_clock_in <= 1'b0;
              wait_reg <= 23'h0;
              state_reg <= S_DESEL;
            end
          end else if (halfDone && serial_clock_in) begin
            firstBit_reg <= 1'b0;
          end
        end
        S_DESEL: begin
          // Hold select low long enough to launch a self-timed cycle.
          wait_reg <= wait_reg + 23'h1;
          if (wait_reg >= 23'(SEL_LOW_CYC)) begin // RQ20
            wait_reg <= 23'h0;
            if (isProgram(cur_reg)) begin
              chipSelect <= 1'b1; // RQ13
              state_reg <= S_POLL;
            end else begin
              state_reg <= S_DONE;
            end
          end
        end
        S_POLL: begin
          // No new frame until ready: a busy device would drop it.
          wait_reg <= wait_reg + 23'h1;
          if (so2_reg && wait_reg > 23'h2) begin // RQ26
            chipSelect <= 1'b0;
            wait_reg <= 23'h0;
            state_reg <= S_DONE;
          end else if (wait_reg >= 23'(PROG_TIMEOUT)) begin // RQ22
            timeoutErr <= 1'b1;
            chipSelect <= 1'b0;
            wait_reg <= 23'h0;
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          // Select was dropped; hold it low for the minimum gap before the next frame.
          // Without this wait a request right after polling would reselect too soon.
          wait_reg <= wait_reg + 23'h1;
          if (wait_reg >= 23'(SEL_LOW_CYC)) begin // RQ20
            doneValid <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  sequence selLowSeq;
    !chipSelect [*8];
  endsequence
  sel_low_gap_a: assert property (@(posedge clk) disable iff (rst) // RQ20
    $fell(chipSelect) |-> selLowSeq) else $error("select low too short");
  poll_bounded_a: assert property (@(posedge clk) disable iff (rst) // RQ22
    state_reg == S_POLL |-> wait_reg <= 23'(PROG_TIMEOUT)) else $error("poll overrun");
  clk_idle_low_a: assert property (@(posedge clk) disable iff (rst) // RQ2
    !chipSelect |-> !serial_clock_in) else $error("clock runs deselected");
  data_stable_a: assert property (@(posedge clk) disable iff (rst) // RQ2
    serial_clock_in |-> $stable(serial_in)) else $error("data moved while clock high");
  // The pin itself must carry the start bit on the cycle select rises.
  frame_start_a: assert property (@(posedge clk) disable iff (rst) // RQ4
    $rose(chipSelect) && state_reg == S_SHIFT |-> serial_in) else $error("no start bit");
  // No request may be offered to the host while a frame or a busy cycle runs.
  busy_no_ready_a: assert property (@(posedge clk) disable iff (rst) // RQ26
    state_reg != S_IDLE |-> !reqReady) else $error("request offered while busy");
endmodule

// ===== verilog/sepc_pkg.sv
package sepc_pkg;
  // Instruction opcodes, two bits after the start bit.
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // Leading address bits that select a special instruction.
  localparam logic [1:0] SUB_LOCK = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_CLEAR = 2'h2;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;
  // Frame lengths: start + opcode + address; then data field widths.
  localparam int FRAME_WORD_BITS = 11;
  localparam int FRAME_BYTE_BITS = 12;
  localparam int DATA_WORD_BITS = 16;
  localparam int DATA_BYTE_BITS = 8;
  // Timing at a 50 MHz system clock.
  localparam int CLK_PERIOD_NS = 20;
  localparam int SK_HALF_NS = 250;
  localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELECT_LOW_MIN_TIME_NS = 250;
  localparam int SEL_LOW_CYC =
    (SELECT_LOW_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_CYCLE_TIME_MS = 5;
  localparam int PROGRAM_CYC = PROGRAM_CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  // Host request carried as one bundle.
  typedef struct packed {
    logic [1:0] op;
    logic [8:0] addr;
    logic [15:0] data;
    logic byteMode;
  } sepc_req_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SHIFT = 3'h1,
    S_DESEL = 3'h3,
    S_POLL = 3'h2,
    S_DONE = 3'h6
  } sepc_state_t;
endpackage
